// ---- rtl/igdp_consts.svh ----
// constants of the isolated gate driver protection block
`ifndef IGDP_CONSTS_SVH
`define IGDP_CONSTS_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define IGDP_CLK_MHZ       200
`define IGDP_INFIL_NS      40
`define IGDP_INFIL_CYC     ((`IGDP_INFIL_NS * `IGDP_CLK_MHZ + 999) / 1000)
`define IGDP_BLANK_NS      200
`define IGDP_BLANK_CYC     ((`IGDP_BLANK_NS * `IGDP_CLK_MHZ + 999) / 1000)
`define IGDP_UVFIL_NS      500
`define IGDP_UVFIL_CYC     ((`IGDP_UVFIL_NS * `IGDP_CLK_MHZ + 999) / 1000)
`define IGDP_CLRFIL_NS     1000
`define IGDP_CLRFIL_CYC    ((`IGDP_CLRFIL_NS * `IGDP_CLK_MHZ + 999) / 1000)
`define IGDP_MUTE_NS       100000
`define IGDP_MUTE_CYC      ((`IGDP_MUTE_NS * `IGDP_CLK_MHZ + 999) / 1000)
// ----------------------------------------
// sensor duty encoder
// ----------------------------------------
`define IGDP_PWM_KHZ       400
`define IGDP_PWM_CYC       (`IGDP_CLK_MHZ * 1000 / `IGDP_PWM_KHZ)
`define IGDP_DUTY_MIN_PCT  10
`define IGDP_DUTY_MAX_PCT  88
`define IGDP_DUTY_MIN_CYC  (`IGDP_PWM_CYC * `IGDP_DUTY_MIN_PCT / 100)
`define IGDP_DUTY_MAX_CYC  (`IGDP_PWM_CYC * `IGDP_DUTY_MAX_PCT / 100)
`define IGDP_AIN_HI_MV     4500
`define IGDP_AIN_LO_MV     600
`define IGDP_MV_PER_CYC    ((`IGDP_AIN_HI_MV - `IGDP_AIN_LO_MV) / (`IGDP_DUTY_MAX_CYC - `IGDP_DUTY_MIN_CYC))
// ----------------------------------------
// register map
// ----------------------------------------
`define IGDP_CTRL_OFS      12'h000
`define IGDP_STATUS_OFS    12'h004
`define IGDP_CTRL_RST      32'h0000_0000
`define IGDP_CTRL_OFF_BIT  0
`define IGDP_ST_UNDERVOLTAGE_LOCKOUT_BIT   0
`define IGDP_ST_FAULT_BIT  1
`define IGDP_ST_EN_BIT     2
`define IGDP_ST_ON_BIT     3
`define IGDP_ST_MUTE_BIT   4
`define IGDP_ST_SOFT_BIT   5
`endif

// ---- rtl/igdp_pkg.sv ----
// types of the isolated gate driver protection block
package igdp_pkg;
  typedef enum logic [1:0] {DRV_SINK, DRV_SOURCE, DRV_SOFT} igdp_drv_t;
  typedef enum logic [1:0] {RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2} igdp_resp_t;
endpackage : igdp_pkg

// ---- rtl/igdp_top.sv ----
// gate driver protection logic with axi4-lite status and control
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`include "igdp_consts.svh"
// How it works
// - gate output forced low while either supply is in lockout.
// - gate may go high only when both supplies are out of lockout.
// - secondary lockout uses separate assert (12 V) and release (+800 mV) flags.
// - lockout flags are deglitched so brief supply dips are ignored.
// - power-good pin driven low during lockout, released otherwise.
// - duty encoder stopped and its output held low during lockout.
// - overcurrent sense node pulled low whenever the gate output is low.
// - overcurrent sensing enabled only in the driver on state.
// - sense ignored for 200 ns blanking after the gate goes high.
// - fault declared when the 9 V comparator flag is set.
// - fault starts soft turn-off through the reduced 400 mA path.
// - fault pin driven low from detection until a valid clear.
// - clear requests during the mute interval after a fault are ignored.
// - low beyond filter time after mute, then rising edge, clears fault.
// - clear/enable low beyond filter time outside the mute window disables driver, sink path active.
// - clear/enable low (or floating) means disabled; high enables.
// - duty rises linearly from 10% at 4.5 V to 88% at 0.6 V.
// - duty output runs at 400 kHz; 5 V input gives about 10%.
// - miller clamp engaged while off and gate below clamp threshold.
// - both inputs high forces the gate low.
// - pulses under 40 ns on both inputs and clear/enable are rejected.
// - gate stays shut down after a fault until a valid clear.
module igdp_top #(
  parameter int MUTE_CYC = `IGDP_MUTE_CYC
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              in_pos,
  input  wire logic              in_neg,
  input  wire logic              clear_enable_in,
  input  wire logic              vcc_uv_cmp,
  input  wire logic              vdd_below_assert_cmp,
  input  wire logic              vdd_above_release_cmp,
  input  wire logic              overcurrent_cmp,
  input  wire logic              gate_below_clamp_cmp,
  input  wire logic [12:0]       sensor_voltage_in,
  output logic                   gate_source_out,
  output logic                   gate_sink_out,
  output logic                   soft_off_out,
  output logic                   overcurrent_sense_pulldown,
  output logic                   overcurrent_sense_bias,
  output logic                   miller_clamp_node,
  output logic                   fault_report_n_o,
  output logic                   fault_report_n_oe,
  output logic                   power_good_o,
  output logic                   power_good_oe,
  output logic                   sensor_duty_out,
  output igdp_pkg::igdp_drv_t    drive_state
);
  import igdp_pkg::*;

  // ----------------------------------------
  // input deglitch filters
  // ----------------------------------------
  localparam int NF = 6;
  logic [NF-1:0] raw_v;
  logic [NF-1:0] filt_r;
  assign raw_v = {vdd_above_release_cmp, vdd_below_assert_cmp, vcc_uv_cmp,
                  clear_enable_in, in_neg, in_pos};

  // a change passes only after it has stood for the full filter length
  for (genvar i = 0; i < NF; i++) begin : g_filt
    localparam logic [7:0] LEN = (i < 3) ? 8'(`IGDP_INFIL_CYC) : 8'(`IGDP_UVFIL_CYC);
    localparam logic       RSTV = (i == 3) || (i == 4);
    logic [7:0] cnt_r;
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        filt_r[i] <= RSTV;
        cnt_r     <= 8'h00;
      end
      else if (raw_v[i] == filt_r[i])
        cnt_r <= 8'h00;
      else if (cnt_r == LEN - 8'h01)
      begin
        filt_r[i] <= raw_v[i];
        cnt_r     <= 8'h00;
      end
      else
        cnt_r <= cnt_r + 8'h01;
    end
  end

  logic pos_f, neg_f, clr_f, vcc_f, vdd_lo_f, vdd_hi_f;
  assign {vdd_hi_f, vdd_lo_f, vcc_f, clr_f, neg_f, pos_f} = filt_r;

  // ----------------------------------------
  // undervoltage lockout
  // ----------------------------------------
  logic vdd_lock_r;
  logic undervoltage_lockout;
  // hysteresis: enter on assert flag, leave only on release flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vdd_lock_r <= 1'b1;
    else if (vdd_lo_f)
      vdd_lock_r <= 1'b1;
    else if (vdd_hi_f)
      vdd_lock_r <= 1'b0;
  end
  assign undervoltage_lockout = vcc_f | vdd_lock_r;

  // ----------------------------------------
  // clear / enable handling
  // ----------------------------------------
  logic        enabled_r;
  logic        fault_r;
  logic        clr_d_r;
  logic        armed_r;
  logic [15:0] low_cnt_r;
  logic [15:0] mute_cnt_r;
  logic        muting;
  logic        low_done;
  logic        clr_rise;
  logic        fault_set;
  assign muting   = fault_r && (mute_cnt_r != 16'(MUTE_CYC));
  assign low_done = (low_cnt_r == 16'(`IGDP_CLRFIL_CYC));
  assign clr_rise = clr_f && !clr_d_r;

  // low time counted only outside the mute window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_cnt_r <= 16'h0000;
    else if (clr_f || muting)
      low_cnt_r <= 16'h0000;
    else if (!low_done)
      low_cnt_r <= low_cnt_r + 16'h0001;
  end

  // enable follows the filtered level, disable after long low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enabled_r <= 1'b0;
      clr_d_r   <= 1'b0;
    end
    else
    begin
      clr_d_r <= clr_f;
      if (low_done)
        enabled_r <= 1'b0;
      else if (clr_f)
        enabled_r <= 1'b1;
    end
  end

  // arm the clear once low stood long enough after the mute
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !fault_r)
      armed_r <= 1'b0;
    else if (low_done)
      armed_r <= 1'b1;
  end

  // ----------------------------------------
  // driver state and overcurrent protection
  // ----------------------------------------
  logic       force_off_r;
  logic       want_on;
  logic       drv_on;
  logic [7:0] blank_cnt_r;
  logic       blank_done;
  assign want_on    = pos_f && !neg_f;
  assign drv_on     = want_on && enabled_r && !fault_r && !undervoltage_lockout && !force_off_r;
  assign blank_done = (blank_cnt_r == 8'(`IGDP_BLANK_CYC));
  assign fault_set  = overcurrent_sense_bias && overcurrent_cmp;

  // blanking counts from the gate rising
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !gate_source_out)
      blank_cnt_r <= 8'h00;
    else if (!blank_done)
      blank_cnt_r <= blank_cnt_r + 8'h01;
  end

  // latched fault with mute timer; detection wins over a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_r    <= 1'b0;
      mute_cnt_r <= 16'h0000;
    end
    else if (fault_set)
    begin
      fault_r    <= 1'b1;
      mute_cnt_r <= 16'h0000;
    end
    else if (fault_r && armed_r && clr_rise)
      fault_r <= 1'b0;
    else if (muting)
      mute_cnt_r <= mute_cnt_r + 16'h0001;
  end

  // output stage selection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      drive_state <= DRV_SINK;
    else if (drv_on)
      drive_state <= DRV_SOURCE;
    else if (fault_r && enabled_r)
      drive_state <= DRV_SOFT;
    else
      drive_state <= DRV_SINK;
  end

  // decode of the stage and sense controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gate_source_out <= 1'b0;
      gate_sink_out   <= 1'b1;
      soft_off_out    <= 1'b0;
    end
    else
    begin
      gate_source_out <= drv_on;
      gate_sink_out   <= !drv_on && !(fault_r && enabled_r);
      soft_off_out    <= !drv_on && fault_r && enabled_r;
    end
  end
  assign overcurrent_sense_pulldown = !gate_source_out;
  assign overcurrent_sense_bias     = gate_source_out && blank_done;

  // miller clamp, fault and power-good pins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      miller_clamp_node <= 1'b0;
      power_good_oe     <= 1'b1;
    end
    else
    begin
      miller_clamp_node <= !drv_on && gate_below_clamp_cmp;
      power_good_oe     <= undervoltage_lockout;
    end
  end
  assign fault_report_n_oe = fault_r;
  assign fault_report_n_o  = 1'b0;
  assign power_good_o      = 1'b0;

  // ----------------------------------------
  // sensor voltage to duty cycle
  // ----------------------------------------
  logic [8:0] pwm_cnt_r;
  logic [8:0] duty_r;
  logic [8:0] duty_nxt;
  always_comb
  begin
    if (sensor_voltage_in >= 13'(`IGDP_AIN_HI_MV))
      duty_nxt = 9'(`IGDP_DUTY_MIN_CYC);
    else if (sensor_voltage_in <= 13'(`IGDP_AIN_LO_MV))
      duty_nxt = 9'(`IGDP_DUTY_MAX_CYC);
    else
      duty_nxt = 9'(`IGDP_DUTY_MIN_CYC) + 9'((13'(`IGDP_AIN_HI_MV) - sensor_voltage_in)
                 / 13'(`IGDP_MV_PER_CYC));
  end

  // duty sampled at each period start so a period is never torn
  always_ff @(posedge aclk)
  begin
    if (!aresetn || undervoltage_lockout)
    begin
      pwm_cnt_r       <= 9'h000;
      duty_r          <= 9'(`IGDP_DUTY_MIN_CYC);
      sensor_duty_out <= 1'b0;
    end
    else
    begin
      pwm_cnt_r       <= (pwm_cnt_r == 9'(`IGDP_PWM_CYC - 1)) ? 9'h000 : pwm_cnt_r + 9'h001;
      if (pwm_cnt_r == 9'(`IGDP_PWM_CYC - 1))
        duty_r <= duty_nxt;
      sensor_duty_out <= (pwm_cnt_r < duty_r);
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic        aw_got_r;
  logic        w_got_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic [31:0] status;
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign status = {26'h000_0000, soft_off_out, muting, gate_source_out, enabled_r, fault_r, undervoltage_lockout};

  // write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb0_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      force_off_r  <= 1'(`IGDP_CTRL_RST);
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r  <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (aw_got_r && w_got_r)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        if (awaddr_r[11:2] == 10'(`IGDP_CTRL_OFS >> 2))
        begin
          if (wstrb0_r)
            force_off_r <= wdata_r[`IGDP_CTRL_OFF_BIT];
        end
        else if (awaddr_r[11:2] != 10'(`IGDP_STATUS_OFS >> 2))
          s_axi_bresp <= RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr[11:2] == 10'(`IGDP_CTRL_OFS >> 2))
        s_axi_rdata <= {31'h0000_0000, force_off_r};
      else if (s_axi_araddr[11:2] == 10'(`IGDP_STATUS_OFS >> 2))
        s_axi_rdata <= status;
      else
        s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_detect;
    fault_set;
  endsequence
  sequence s_shutdown;
    ##1 fault_report_n_oe ##1 (!gate_source_out && soft_off_out == enabled_r);
  endsequence

  AST_UNDERVOLTAGE_LOCKOUT_GATE: assert property (undervoltage_lockout |=> !gate_source_out)
    else $error("gate high during lockout");
  AST_BOTH_OK: assert property ($rose(gate_source_out) |-> $past(!undervoltage_lockout))
    else $error("gate rose while a supply was locked out");
  AST_UV_PINS: assert property (undervoltage_lockout |=> power_good_oe && !sensor_duty_out)
    else $error("power good or duty active during lockout");
  AST_INTERLOCK: assert property (pos_f && neg_f |=> !gate_source_out)
    else $error("gate high with both inputs high");
  AST_BLANK: assert property (overcurrent_sense_bias |-> $past(gate_source_out, 40))
    else $error("sense enabled before blanking ended");
  AST_SENSE_OFF: assert property (!gate_source_out |-> overcurrent_sense_pulldown
                                  && !overcurrent_sense_bias)
    else $error("sense active while gate low");
  AST_FAULT_SEQ: assert property (s_detect |-> s_shutdown)
    else $error("fault did not shut the gate down");
  AST_MUTE: assert property (muting && clr_rise |=> fault_r)
    else $error("clear accepted during mute");
  AST_CLEAR: assert property (fault_r && armed_r && clr_rise && !fault_set |=> !fault_r)
    else $error("valid clear ignored");
  AST_DISABLE: assert property (low_done |=> !enabled_r ##1 gate_sink_out || soft_off_out)
    else $error("long low did not disable the driver");
  AST_DEGLITCH: assert property ($changed(pos_f) |-> $past(in_pos, 1) == pos_f
                                 && $past(in_pos, 8) == pos_f)
    else $error("short pulse passed the input filter");

endmodule : igdp_top

// ---- dv/igdp_host.sv ----
// host controller model driving the pwm and clear/enable pins
`include "igdp_consts.svh"
module igdp_host (
  input  wire logic aclk,
  input  wire logic fault_n,
  input  wire logic power_good,
  output logic      in_pos,
  output logic      in_neg,
  output logic      clear_enable_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // all pins low at power-up, driver disabled
  initial
  begin
    in_pos = 1'b0;
    in_neg = 1'b0;
    clear_enable_in = 1'b0;
  end
  // new levels land just after the edge just taken; the next edge samples them
  task set(input logic p, input logic n, input logic e);
    in_pos <= p;
    in_neg <= n;
    clear_enable_in <= e;
  endtask : set
  // long low past the clear filter, then the rising edge
  task clear();
    clear_enable_in <= 1'b0;
    repeat (`IGDP_CLRFIL_CYC + 10) @(posedge aclk);
    clear_enable_in <= 1'b1;
  endtask : clear
endmodule : igdp_host

// ---- dv/tb_igdp_top.sv ----
// self-checking bench of the gate driver protection logic
`include "igdp_consts.svh"
module tb_igdp_top;
  timeunit 1ns;
  timeprecision 100ps;
  import igdp_pkg::*;
  localparam int MUTE = 400;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic in_pos, in_neg, clear_enable_in;
  logic vcc_uv_cmp = 0, vdd_below_assert_cmp = 1, vdd_above_release_cmp = 0;
  logic overcurrent_cmp = 0, gate_below_clamp_cmp = 0;
  logic [12:0] sensor_voltage_in = 13'h1388;
  logic gate_source_out, gate_sink_out, soft_off_out, miller_clamp_node;
  logic overcurrent_sense_pulldown, overcurrent_sense_bias, sensor_duty_out;
  logic fault_report_n_o, fault_report_n_oe, power_good_o, power_good_oe;
  igdp_drv_t drive_state;
  wire fault_n = fault_report_n_oe ? fault_report_n_o : 1'b1; // pull-up
  wire power_good = power_good_oe ? power_good_o : 1'b1;
  int n_mismatch = 0, checks_done = 0, i, hi, per, mv;
  logic [15:0] lfsr = 16'h0ECD;
  logic [1:0] rsp;
  logic [31:0] rd;
  int corner[4] = '{5000, 4500, 600, 0};
  igdp_top #(.MUTE_CYC(MUTE)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_pos, .in_neg, .clear_enable_in, .vcc_uv_cmp, .vdd_below_assert_cmp,
    .vdd_above_release_cmp, .overcurrent_cmp, .gate_below_clamp_cmp,
    .sensor_voltage_in, .gate_source_out, .gate_sink_out, .soft_off_out,
    .overcurrent_sense_pulldown, .overcurrent_sense_bias, .miller_clamp_node,
    .fault_report_n_o, .fault_report_n_oe, .power_good_o, .power_good_oe,
    .sensor_duty_out, .drive_state);
  igdp_host host (.aclk, .fault_n, .power_good, .in_pos, .in_neg, .clear_enable_in);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // 200 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // expected high time of one duty period
  function automatic int exp_hi(input int v);
    if (v >= `IGDP_AIN_HI_MV) return `IGDP_DUTY_MIN_CYC;
    if (v <= `IGDP_AIN_LO_MV) return `IGDP_DUTY_MAX_CYC;
    return `IGDP_DUTY_MIN_CYC + (`IGDP_AIN_HI_MV - v) / `IGDP_MV_PER_CYC;
  endfunction : exp_hi
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task test_done();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // axi4-lite write; entered just after an edge
  task axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    cyc(1);
  endtask : axw
  // axi4-lite read
  task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h3;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    cyc(1);
  endtask : axr
  // one full duty period, rise to rise
  task dmeas();
    int k;
    for (k = 0; k < 1000 && sensor_duty_out !== 1'b0; k++) cyc(1);
    for (k = 0; k < 1000 && sensor_duty_out !== 1'b1; k++) cyc(1);
    for (hi = 0; hi < 1000 && sensor_duty_out === 1'b1; hi++) cyc(1);
    for (per = hi; per < 1000 && sensor_duty_out === 1'b0; per++) cyc(1);
  endtask : dmeas
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    #250000;
    n_mismatch++;
    $display("[FAIL] watchdog expected done seen hang");
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    aresetn = 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    #1;
    chk("sink", 1, gate_sink_out);
    chk("fault_oe", 0, fault_report_n_oe);
    cyc(1);
    host.set(1, 0, 1);
    cyc(250);
    #1;
    chk("src_uv", 0, gate_source_out);
    chk("pg_uv", 1, power_good_oe);
    chk("duty_uv", 0, sensor_duty_out);
    // short supply recovery glitch
    cyc(1);
    vdd_below_assert_cmp <= 1'b0;
    vdd_above_release_cmp <= 1'b1;
    cyc(50);
    vdd_below_assert_cmp <= 1'b1;
    vdd_above_release_cmp <= 1'b0;
    cyc(60);
    #1;
    chk("pg_dip", 1, power_good_oe);
    // inside the hysteresis band the lockout must hold
    cyc(1);
    vdd_below_assert_cmp <= 1'b0;
    cyc(120);
    #1;
    chk("pg_band", 1, power_good_oe);
    cyc(1);
    vdd_above_release_cmp <= 1'b1;
    cyc(120);
    #1;
    chk("pg_ok", 0, power_good_oe);
    chk("pg_pin", 1, power_good);
    chk("src_on", 1, gate_source_out);
    // interlock, clamp and rejected short pulse
    cyc(1);
    host.set(1, 1, 1);
    gate_below_clamp_cmp <= 1'b1;
    cyc(12);
    #1;
    chk("src_both", 0, gate_source_out);
    chk("pulldown", 1, overcurrent_sense_pulldown);
    chk("bias_off", 0, overcurrent_sense_bias);
    chk("clamp", 1, miller_clamp_node);
    cyc(1);
    gate_below_clamp_cmp <= 1'b0;
    lfsr = lfsr_next(lfsr);
    host.set(1, 0, 1);
    cyc(1 + lfsr % 7);
    host.set(1, 1, 1);
    cyc(12);
    #1;
    chk("src_glitch", 0, gate_source_out);
    // sensing blanked, then a real overcurrent
    cyc(1);
    host.set(0, 0, 1);
    cyc(12);
    host.set(1, 0, 1);
    cyc(12);
    overcurrent_cmp <= 1'b1;
    cyc(18);
    #1;
    chk("bias_blank", 0, overcurrent_sense_bias);
    chk("fault_blank", 0, fault_report_n_oe);
    cyc(1);
    overcurrent_cmp <= 1'b0;
    cyc(40);
    #1;
    chk("bias_on", 1, overcurrent_sense_bias);
    cyc(1);
    overcurrent_cmp <= 1'b1;
    cyc(3);
    #1;
    chk("fault_oe", 1, fault_report_n_oe);
    chk("fault_pin", 0, fault_n);
    chk("soft", 1, soft_off_out);
    chk("state", DRV_SOFT, drive_state);
    chk("src_flt", 0, gate_source_out);
    cyc(1);
    overcurrent_cmp <= 1'b0;
    host.clear();
    cyc(20);
    #1;
    chk("fault_mute", 1, fault_report_n_oe);
    chk("src_mute", 0, gate_source_out);
    cyc(MUTE);
    host.clear();
    cyc(20);
    #1;
    chk("fault_clr", 0, fault_report_n_oe);
    chk("src_clr", 1, gate_source_out);
    // long low disables the driver
    cyc(1);
    host.set(1, 0, 0);
    cyc(100);
    #1;
    chk("src_filt", 1, gate_source_out);
    cyc(120);
    #1;
    chk("src_dis", 0, gate_source_out);
    chk("sink_dis", 1, gate_sink_out);
    cyc(1);
    host.set(1, 0, 1);
    cyc(20);
    // register bus
    axr(12'h004, rd, rsp);
    chk("st_resp", RESP_OKAY, rsp);
    chk("status", 32'h0000_000C, rd);
    axw(12'h000, 32'h0000_0001, rsp);
    chk("ctrl_resp", RESP_OKAY, rsp);
    cyc(5);
    #1;
    chk("src_force", 0, gate_source_out);
    cyc(1);
    axr(12'h000, rd, rsp);
    chk("ctrl", 32'h0000_0001, rd);
    axw(12'h000, 32'h0000_0000, rsp);
    axr(12'h008, rd, rsp);
    chk("bad_rresp", RESP_SLVERR, rsp);
    chk("bad_rdata", 0, rd);
    axw(12'h010, 32'h0000_0001, rsp);
    chk("bad_bresp", RESP_SLVERR, rsp);
    // duty encoder, corners then random voltages
    for (i = 0; i < 7; i++)
    begin
      lfsr = lfsr_next(lfsr);
      mv = (i < 4) ? corner[i] : 600 + lfsr % 3901;
      sensor_voltage_in <= 13'(mv);
      dmeas();
      dmeas();
      chk("duty_hi", exp_hi(mv), hi);
      chk("duty_per", `IGDP_PWM_CYC, per);
    end
    // supply lost again
    vdd_below_assert_cmp <= 1'b1;
    vdd_above_release_cmp <= 1'b0;
    cyc(120);
    #1;
    chk("src_uv2", 0, gate_source_out);
    chk("pg_uv2", 0, power_good);
    chk("duty_uv2", 0, sensor_duty_out);
    test_done();
  end
endmodule : tb_igdp_top
